// file: dmaorq_pkg.sv
// package: constants and types for the one-bus-cycle dma request logic
package dmaorq_pkg;
	localparam int NCH = 4;
	localparam logic [3:0] SRC_NONE = 4'h0;
	localparam logic [3:0] SRC_EXT = 4'h1;
	localparam logic [3:0] SRC_SW = 4'h2;
	localparam logic [3:0] SRC_TA0 = 4'h3;
	localparam logic [3:0] SRC_AD = 4'hF;
	localparam int NPERIPH = 13;
	localparam int CTL_SRC_LSB = 0;
	localparam int CTL_SENSE_BIT = 4;
	localparam int CTL_GRANT_EN_BIT = 5;
	localparam int MODE_UNIT8_BIT = 0;
	localparam int MODE_ONEBUS_BIT = 1;
	localparam int MODE_STEAL_BIT = 2;
	localparam int MODE_IO2MEM_BIT = 8;
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [15:0] MODE_RESET = 16'h0000;
	localparam logic [1:0] CH_NONE = 2'h0;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_XFER = 3'b010,
		ST_DONE = 3'b100
	} dmaorq_state_e;
endpackage

// file: dmaorq_sync_if.sv
// interface: synchronised external request levels and falling edges between sampler and core
`timescale 1ns/10ps
interface dmaorq_sync_if;
	logic [3:0] req_low;
	logic [3:0] req_fall;
	modport src (output req_low, output req_fall);
	modport dst (input req_low, input req_fall);
endinterface

// file: dmaorq_sync.sv
// module: three-flop sampler for the external request pins
`timescale 1ns/10ps
module dmaorq_sync #(
	parameter int N = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [N-1:0] pin_n,
	dmaorq_sync_if.src sy
);
	typedef struct packed {
		logic [N-1:0] s1;
		logic [N-1:0] s2;
		logic [N-1:0] s3;
		logic [N-1:0] lvl;
	} dmaorq_sy_s;
	dmaorq_sy_s st_q, st_d;
	logic [N-1:0] agree;
	always_comb begin
		st_d = st_q;
		st_d.s1 = pin_n;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		// a change counts only once the second and third stages agree
		agree = ~(st_q.s2 ^ st_q.s3);
		st_d.lvl = (agree & st_q.s3) | (~agree & st_q.lvl);
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= '1;
		end else begin
			st_q <= st_d;
		end
	end
	assign sy.req_low = ~st_q.lvl;
	assign sy.req_fall = st_q.lvl & ~st_d.lvl;
endmodule

// file: dmaorq_core.sv
// module: one-bus-cycle dma request, acceptance and byte-lane steering
//
// Contract
// - memory to io, 16-bit units on 16-bit bus: source address, read, both strobes low
// - io to memory: grant asserted, destination address driven, direction low
// - forward: low address byte on low lane; backward: higher byte on high lane
// - 8-bit io low lane: odd byte read high, copied, driven on low lane
// - 8-bit io low lane: even byte passes directly, low data pins float
// - io high lane: odd passes with high pins floating; even copied upward
// - data pin group directions switch automatically per io lane position
// - strobes: both low for 16-bit units, one for 8-bit, none on 8-bit bus
// - each channel picks one of fifteen sources, interrupt timing for internals
// - source code decode: prohibited, external, software, timers, uarts, ad
// - software bit sets request flag, clears itself once flag is one
// - external pin activity sets request flag when external source selected
// - accept only when permission bit and request flag are both one
// - permission bits clear on reset; software sets parameters first
// - mode bit 2 per channel, zero burst, burst after reset
// - burst: other channels refused until accepted channel completes; code also releases it once its flag or permission bit drops
// - burst: edge or level choice only with external pin source
// - mode bit 2 one selects cycle steal with edge sensing
// - control bit 4: zero falling edge default, one level for pin only
// - mode bit 1 one selects one-bus-cycle, zero two-bus-cycle
// - mode bit 8: zero memory to io, one io to memory
`timescale 1ns/10ps
module dmaorq_core #(
	parameter int AW = 24
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic [31:0] CTL,
	input wire logic [63:0] MODE,
	input wire logic [3:0] PERMIT,
	input wire logic [3:0] SW_REQ_WR,
	input wire logic [3:0] FLAG_CLR,
	input wire logic [dmaorq_pkg::NPERIPH-1:0] PERIPH_REQ,
	input wire logic [3:0] XFER_REQ_IN_N,
	input wire logic [4*AW-1:0] SRC_ADDR,
	input wire logic [4*AW-1:0] DST_ADDR,
	input wire logic [3:0] BACKWARD,
	input wire logic [3:0] UNIT_DONE,
	input wire logic [3:0] XFER_COMPLETE,
	input wire logic BUS16,
	input wire logic IO_HIGH_LANE,
	input wire logic [15:0] DATA_IN,
	output logic [3:0] REQ_FLAG,
	output logic [3:0] SW_REQ_PEND,
	output logic [3:0] XFER_GRANT_OUT_N,
	output logic [AW-1:0] ADDR,
	output logic RW_READ,
	output logic LOW_BYTE_STROBE_N,
	output logic HIGH_BYTE_STROBE_N,
	output logic [15:0] DATA_OUT,
	output logic DATA_LO_OE,
	output logic DATA_HI_OE,
	output logic BUSY,
	output logic [1:0] ACTIVE_CH,
	output logic CONFIG_ERR
);
	localparam int N = dmaorq_pkg::NCH;
	dmaorq_sync_if sy();
	dmaorq_sync #(.N(N)) u_sync (
		.clk(CLK),
		.rst(RST),
		.pin_n(XFER_REQ_IN_N),
		.sy(sy)
	);

	typedef struct packed {
		dmaorq_pkg::dmaorq_state_e st;
		logic [N-1:0] flag;
		logic [N-1:0] sw;
		logic [1:0] ch;
		logic [N-1:0] grant_n;
		logic [AW-1:0] addr;
		logic rw;
		logic ble_n;
		logic bhe_n;
		logic [15:0] dout;
		logic lo_oe;
		logic hi_oe;
		logic busy;
		logic err;
		logic [N-1:0] permit;
	} dmaorq_st_s;
	dmaorq_st_s q, d;

	// map a source code onto its request line; prohibited and software give none
	function automatic logic src_hit(input logic [3:0] sel, input logic [dmaorq_pkg::NPERIPH-1:0] per,
		input logic ext);
		logic r;
		r = 1'b0;
		if (sel == dmaorq_pkg::SRC_EXT) begin
			r = ext;
		end else if (sel >= dmaorq_pkg::SRC_TA0) begin
			r = per[4'(sel - dmaorq_pkg::SRC_TA0)];
		end
		return r;
	endfunction

	function automatic logic [3:0] ctl_src(input logic [7:0] c);
		return c[dmaorq_pkg::CTL_SRC_LSB +: 4];
	endfunction

	logic [7:0] c [N];
	logic [15:0] m [N];
	logic [N-1:0] ev;
	logic [N-1:0] accept;
	logic [1:0] pick;
	logic found;
	logic [15:0] cm;
	logic [7:0] cc;
	logic odd;
	logic [N-1:0] permit_fell;
	logic [AW-1:0] xa;

	always_comb begin
		d = q;
		ev = '0;
		accept = '0;
		pick = dmaorq_pkg::CH_NONE;
		found = 1'b0;
		// a forced stop is the permission bit falling; a flag raised while it is low must stand
		permit_fell = q.permit & ~PERMIT;
		d.permit = PERMIT;
		for (int i = 0; i < N; i++) begin
			c[i] = CTL[8*i +: 8];
			m[i] = MODE[16*i +: 16];
		end
		for (int i = 0; i < N; i++) begin
			// internal sources arrive as pulses timed like their interrupts
			ev[i] = src_hit(ctl_src(c[i]), PERIPH_REQ, sy.req_fall[i]);
			// level sensing only for the pin source in burst mode
			if (c[i][dmaorq_pkg::CTL_SENSE_BIT] && ctl_src(c[i]) == dmaorq_pkg::SRC_EXT
				&& !m[i][dmaorq_pkg::MODE_STEAL_BIT]) begin
				d.flag[i] = sy.req_low[i];
			end else begin
				if (FLAG_CLR[i]) begin
					d.flag[i] = 1'b0;
				end
				if (permit_fell[i] && !m[i][dmaorq_pkg::MODE_STEAL_BIT]) begin
					d.flag[i] = 1'b0;
				end
				if (XFER_COMPLETE[i] && q.busy && q.ch == 2'(i)) begin
					d.flag[i] = 1'b0;
				end
				// set wins over the clears above; the steal acceptance clear in idle still wins over set
				if (ev[i] || (q.sw[i] && ctl_src(c[i]) == dmaorq_pkg::SRC_SW)) begin
					d.flag[i] = 1'b1;
				end
			end
			if (SW_REQ_WR[i]) begin
				d.sw[i] = 1'b1;
			end else if (q.flag[i]) begin
				d.sw[i] = 1'b0;
			end
			// lowest channel wins here; full priority handling sits outside this block
			accept[i] = PERMIT[i] && q.flag[i];
			if (accept[i] && !found) begin
				found = 1'b1;
				pick = 2'(i);
			end
		end
		cm = m[q.ch];
		cc = c[q.ch];
		// strobes and lanes follow the address being driven now, not the one before
		xa = cm[dmaorq_pkg::MODE_IO2MEM_BIT] ? DST_ADDR[AW*q.ch +: AW] : SRC_ADDR[AW*q.ch +: AW];
		odd = xa[0];

		case (q.st)
			dmaorq_pkg::ST_IDLE: begin
				d.grant_n = '1;
				d.lo_oe = 1'b0;
				d.hi_oe = 1'b0;
				d.ble_n = 1'b1;
				d.bhe_n = 1'b1;
				d.rw = 1'b1;
				d.busy = 1'b0;
				if (found && m[pick][dmaorq_pkg::MODE_ONEBUS_BIT]) begin
					d.st = dmaorq_pkg::ST_XFER;
					d.ch = pick;
					d.busy = 1'b1;
					if (m[pick][dmaorq_pkg::MODE_STEAL_BIT]) begin
						d.flag[pick] = 1'b0;
					end
				end
			end

			dmaorq_pkg::ST_XFER: begin
				// burst locks out others; steal re-arbitrates after each unit
				if (cc[dmaorq_pkg::CTL_GRANT_EN_BIT]) begin
					d.grant_n = ~(N'(1) << q.ch);
				end
				if (cm[dmaorq_pkg::MODE_IO2MEM_BIT]) begin
					d.addr = DST_ADDR[AW*q.ch +: AW];
					d.rw = 1'b0;
				end else begin
					d.addr = SRC_ADDR[AW*q.ch +: AW];
					d.rw = 1'b1;
				end
				d.lo_oe = 1'b0;
				d.hi_oe = 1'b0;
				d.ble_n = 1'b1;
				d.bhe_n = 1'b1;
				if (!BUS16) begin
					// no strobes on an 8-bit bus; io must sit low
					d.err = IO_HIGH_LANE;
				end else if (!cm[dmaorq_pkg::MODE_UNIT8_BIT]) begin
					// whole word on both lanes keeps byte order per direction
					d.ble_n = 1'b0;
					d.bhe_n = 1'b0;
					d.err = BACKWARD[q.ch] ? !odd : odd;
				end else begin
					d.ble_n = odd;
					d.bhe_n = !odd;
					// copy path only on memory reads; lane turnaround automatic
					// the first beat copies the idle bus; the io only takes data at the strobe's end
					if (!cm[dmaorq_pkg::MODE_IO2MEM_BIT]) begin
						if (!IO_HIGH_LANE && odd) begin
							d.dout = {DATA_IN[15:8], DATA_IN[15:8]};
							d.lo_oe = 1'b1;
						end else if (IO_HIGH_LANE && !odd) begin
							d.dout = {DATA_IN[7:0], DATA_IN[7:0]};
							d.hi_oe = 1'b1;
						end
						// direct lane case leaves both groups floating
					end
				end
				if (UNIT_DONE[q.ch] || XFER_COMPLETE[q.ch] || !PERMIT[q.ch]) begin
					d.st = dmaorq_pkg::ST_DONE;
				end
			end

			dmaorq_pkg::ST_DONE: begin
				d.grant_n = '1;
				d.lo_oe = 1'b0;
				d.hi_oe = 1'b0;
				d.ble_n = 1'b1;
				d.bhe_n = 1'b1;
				d.rw = 1'b1;
				// burst keeps the channel until complete, flag drops or permission bit drops
				if (!cm[dmaorq_pkg::MODE_STEAL_BIT] && PERMIT[q.ch] && q.flag[q.ch]
					&& !XFER_COMPLETE[q.ch]) begin
					d.st = dmaorq_pkg::ST_XFER;
				end else begin
					d.st = dmaorq_pkg::ST_IDLE;
					d.busy = 1'b0;
				end
			end

			default: begin
				d.st = dmaorq_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			q <= '{st: dmaorq_pkg::ST_IDLE, flag: '0, sw: '0, ch: dmaorq_pkg::CH_NONE, grant_n: '1,
				addr: '0, rw: 1'b1, ble_n: 1'b1, bhe_n: 1'b1, dout: '0, lo_oe: 1'b0, hi_oe: 1'b0,
				busy: 1'b0, err: 1'b0, permit: '0};
		end else begin
			q <= d;
		end
	end

	assign REQ_FLAG = q.flag;
	assign SW_REQ_PEND = q.sw;
	assign XFER_GRANT_OUT_N = q.grant_n;
	assign ADDR = q.addr;
	assign RW_READ = q.rw;
	assign LOW_BYTE_STROBE_N = q.ble_n;
	assign HIGH_BYTE_STROBE_N = q.bhe_n;
	assign DATA_OUT = q.dout;
	assign DATA_LO_OE = q.lo_oe;
	assign DATA_HI_OE = q.hi_oe;
	assign BUSY = q.busy;
	assign ACTIVE_CH = q.ch;
	assign CONFIG_ERR = q.err;
endmodule

// file: dmaorq_checker.sv
// checker: port assertions for the dma request core
`timescale 1ns/10ps
module dmaorq_checker #(
	parameter int AW = 24
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic [31:0] CTL,
	input wire logic [63:0] MODE,
	input wire logic [3:0] PERMIT,
	input wire logic [3:0] SW_REQ_WR,
	input wire logic BUS16,
	input wire logic IO_HIGH_LANE,
	input wire logic [3:0] REQ_FLAG,
	input wire logic [AW-1:0] ADDR,
	input wire logic RW_READ,
	input wire logic LOW_BYTE_STROBE_N,
	input wire logic HIGH_BYTE_STROBE_N,
	input wire logic DATA_LO_OE,
	input wire logic DATA_HI_OE,
	input wire logic BUSY,
	input wire logic [1:0] ACTIVE_CH
);
	logic [15:0] m;
	logic cy, b8;
	logic [3:0] ok_q;
	assign m = MODE[ACTIVE_CH*16 +: 16];
	assign cy = !(LOW_BYTE_STROBE_N && HIGH_BYTE_STROBE_N);
	// byte units from memory to io on the wide bus are the only case with lane steering
	assign b8 = cy && BUS16 && m[0] && !m[8];
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ok_q <= 4'h0;
		end else begin
			ok_q <= REQ_FLAG & PERMIT;
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	a_word_strobes: assert property (
		cy && BUS16 && !m[0] |-> !LOW_BYTE_STROBE_N && !HIGH_BYTE_STROBE_N) else $error("word strobes");
	a_byte_strobes: assert property (
		cy && BUS16 && m[0] |-> LOW_BYTE_STROBE_N == ADDR[0] && HIGH_BYTE_STROBE_N != ADDR[0]) else $error("byte strobe");
	a_dir_matches: assert property (
		cy |-> RW_READ == !m[8]) else $error("direction");
	a_copy_drives: assert property (
		b8 && ADDR[0] != IO_HIGH_LANE |-> DATA_HI_OE == IO_HIGH_LANE && DATA_LO_OE != IO_HIGH_LANE) else $error("copy");
	a_direct_floats: assert property (
		b8 && ADDR[0] == IO_HIGH_LANE |-> !DATA_LO_OE && !DATA_HI_OE) else $error("float");
	a_burst_lock: assert property (
		BUSY && $past(BUSY) && !m[2] |-> $stable(ACTIVE_CH)) else $error("lock");
	a_accept_both: assert property (
		$rose(BUSY) |-> ok_q[ACTIVE_CH] && MODE[ACTIVE_CH*16+1]) else $error("accept");
	a_soft_flag: assert property (
		SW_REQ_WR[0] && CTL[3:0] == dmaorq_pkg::SRC_SW |-> ##[1:3] REQ_FLAG[0]) else $error("soft flag");
endmodule

// file: dmaorq_bus_model.sv
// partner: bus memory and io device answering one-bus-cycle transfers
`timescale 1ns/10ps
module dmaorq_bus_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] grant_n,
	input wire logic rw_read,
	input wire logic lo_n,
	input wire logic hi_n,
	output logic [15:0] data_in,
	output logic [3:0] unit_done,
	output logic [15:0] io_q
);
	logic [2:0] cnt;
	logic [15:0] idle_q;
	// memory drives on reads, io on memory writes; a released bus wobbles every cycle
	assign data_in = (lo_n && hi_n) ? idle_q : (rw_read ? 16'hA53C : 16'h5AC3);
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 3'h0;
			idle_q <= 16'h0000;
			unit_done <= 4'h0;
			io_q <= 16'h0000;
		end else begin
			idle_q <= ~idle_q;
			cnt <= (&grant_n) ? 3'h0 : cnt + 3'h1;
			unit_done <= (cnt == 3'h5) ? ~grant_n : 4'h0;
			if (!(&grant_n) && rw_read && !lo_n) begin
				io_q <= data_in;
			end
		end
	end
endmodule

// file: tb_dmaorq_core.sv
// testbench: request, acceptance, burst lock and lane steering of the dma core
`timescale 1ns/10ps
module tb_dmaorq_core;
	logic CLK = 1'b0, RST = 1'b1, BUS16 = 1'b1, IO_HIGH_LANE = 1'b0;
	logic [31:0] CTL = 32'h2222_2122;
	logic [63:0] MODE = 64'h0000_0000_0102_0002;
	logic [3:0] PERMIT = 4'h0, SW_REQ_WR = 4'h0, FLAG_CLR = 4'h0, XFER_REQ_IN_N = 4'hF, BACKWARD = 4'h0;
	logic [12:0] PERIPH_REQ = 13'h0000;
	logic [95:0] SRC_ADDR = 96'h0000_0000_0000_0000_0000_1000, DST_ADDR = 96'h0000_0000_0000_0020_0000_0000;
	logic [3:0] UNIT_DONE, REQ_FLAG, SW_REQ_PEND, XFER_GRANT_OUT_N;
	logic [15:0] DATA_IN, DATA_OUT, io_q;
	logic [23:0] ADDR;
	logic RW_READ, LOW_BYTE_STROBE_N, HIGH_BYTE_STROBE_N, DATA_LO_OE, DATA_HI_OE, BUSY, CONFIG_ERR;
	logic [1:0] ACTIVE_CH;
	int fails = 0, comparisons = 0, cycle_count = 0, k;
	always #2 CLK = ~CLK;
	// one unit per transfer, so each unit also ends the transfer
	dmaorq_core #(.AW(24)) DUT (.CLK, .RST, .CTL, .MODE, .PERMIT, .SW_REQ_WR, .FLAG_CLR, .PERIPH_REQ, .XFER_REQ_IN_N,
		.SRC_ADDR, .DST_ADDR, .BACKWARD, .UNIT_DONE, .XFER_COMPLETE(UNIT_DONE), .BUS16, .IO_HIGH_LANE, .DATA_IN,
		.REQ_FLAG, .SW_REQ_PEND, .XFER_GRANT_OUT_N, .ADDR, .RW_READ, .LOW_BYTE_STROBE_N, .HIGH_BYTE_STROBE_N,
		.DATA_OUT, .DATA_LO_OE, .DATA_HI_OE, .BUSY, .ACTIVE_CH, .CONFIG_ERR);
	dmaorq_bus_model u_bus (.clk(CLK), .rst(RST), .grant_n(XFER_GRANT_OUT_N), .rw_read(RW_READ),
		.lo_n(LOW_BYTE_STROBE_N), .hi_n(HIGH_BYTE_STROBE_N), .data_in(DATA_IN), .unit_done(UNIT_DONE), .io_q(io_q));
	task finish_test;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task sw(input int ch);
		SW_REQ_WR[ch] = 1'b1;
		@(negedge CLK);
		SW_REQ_WR = 4'h0;
	endtask
	task until_grant(input int ch, input logic v);
		int i;
		for (i = 0; i < 60 && XFER_GRANT_OUT_N[ch] !== v; i++) @(negedge CLK);
		chk("grant", v, XFER_GRANT_OUT_N[ch]);
	endtask
	always @(posedge CLK) begin
		cycle_count++;
		if (cycle_count == 3000) begin
			fails++;
			finish_test();
		end
	end
	initial begin
		repeat (10) @(negedge CLK);
		RST = 1'b0;
		@(negedge CLK);
		chk("flags", 4'h0, REQ_FLAG);
		chk("grants", 4'hF, XFER_GRANT_OUT_N);
		sw(0);
		repeat (4) @(negedge CLK);
		chk("flag0", 1'b1, REQ_FLAG[0]);
		chk("pend0", 1'b0, SW_REQ_PEND[0]);
		chk("busy", 1'b0, BUSY);
		PERMIT = 4'h2;
		XFER_REQ_IN_N[1] = 1'b0;
		until_grant(1, 1'b0);
		PERMIT = 4'h3;
		chk("addr", 24'h00_2000, ADDR);
		chk("rw", 1'b0, RW_READ);
		XFER_REQ_IN_N[1] = 1'b1;
		sw(0);
		repeat (2) @(negedge CLK);
		chk("lock", 2'h1, ACTIVE_CH);
		until_grant(0, 1'b0);
		chk("addr", 24'h00_1000, ADDR);
		chk("strobes", 2'b00, {LOW_BYTE_STROBE_N, HIGH_BYTE_STROBE_N});
		chk("cfg", 1'b0, CONFIG_ERR);
		until_grant(0, 1'b1);
		chk("io", 16'hA53C, io_q);
		MODE[0] = 1'b1;
		for (k = 0; k < 4; k++) begin
			IO_HIGH_LANE = k[1];
			SRC_ADDR[0] = k[0];
			sw(0);
			until_grant(0, 1'b0);
			chk("ble", k[0], LOW_BYTE_STROBE_N);
			while (UNIT_DONE[0] !== 1'b1 && XFER_GRANT_OUT_N[0] === 1'b0) @(negedge CLK);
			if (k == 1) chk("copy lo", 16'hA5A5, DATA_OUT);
			if (k == 2) chk("copy hi", 16'h3C3C, DATA_OUT);
			until_grant(0, 1'b1);
		end
		// cycle steal on an 8-bit bus: flag drops at acceptance, no strobes, io lane kept low
		MODE[2] = 1'b1;
		BUS16 = 1'b0;
		IO_HIGH_LANE = 1'b0;
		sw(0);
		until_grant(0, 1'b0);
		chk("steal flag", 1'b0, REQ_FLAG[0]);
		chk("bus8 strobes", 2'b11, {LOW_BYTE_STROBE_N, HIGH_BYTE_STROBE_N});
		chk("bus8 cfg", 1'b0, CONFIG_ERR);
		until_grant(0, 1'b1);
		repeat (2) @(negedge CLK);
		chk("steal idle", 1'b0, BUSY);
		MODE[2] = 1'b0;
		BUS16 = 1'b1;
		// level sensing on the pin source: the flag follows the pin level, not its edge
		CTL[12] = 1'b1;
		XFER_REQ_IN_N[1] = 1'b0;
		until_grant(1, 1'b0);
		chk("level flag", 1'b1, REQ_FLAG[1]);
		XFER_REQ_IN_N[1] = 1'b1;
		repeat (6) @(negedge CLK);
		chk("level drop", 1'b0, REQ_FLAG[1]);
		until_grant(1, 1'b1);
		repeat (2) @(negedge CLK);
		chk("level idle", 1'b0, BUSY);
		CTL[12] = 1'b0;
		// channel 2 stays without permission so every flag is left standing for the check
		for (k = 0; k < 16; k++) begin
			CTL[19:16] = k[3:0];
			@(negedge CLK);
			PERIPH_REQ = (k > 2) ? 13'h0001 << (k - 3) : 13'h1FFF;
			@(negedge CLK);
			PERIPH_REQ = 13'h0000;
			repeat (3) @(negedge CLK);
			chk("source", k > 2, REQ_FLAG[2]);
			FLAG_CLR[2] = 1'b1;
			@(negedge CLK);
			FLAG_CLR = 4'h0;
		end
		finish_test();
	end
endmodule
bind dmaorq_core dmaorq_checker #(.AW(AW)) u_chk (.CLK, .RST, .CTL, .MODE, .PERMIT, .SW_REQ_WR, .BUS16,
	.IO_HIGH_LANE, .REQ_FLAG, .ADDR, .RW_READ, .LOW_BYTE_STROBE_N, .HIGH_BYTE_STROBE_N, .DATA_LO_OE, .DATA_HI_OE,
	.BUSY, .ACTIVE_CH);
